// *** src/kgr_regs.svh ***
// Register offsets, command codes, field positions and timing constants of the gate/reset block
// Function
// - Self-test command AAh loads 55h into the output buffer.
// - Interface test ABh returns 00, or 01 for keyboard clock stuck low, 03 for keyboard data stuck low.
// - Command C0h loads the sampled input port into the output buffer.
// - C1h/C2h keep copying low/high input port nibble into the status register.
// - Command D0h loads the output port value into the output buffer.
// - After D1h the next data byte sets or clears the gate from bit 1.
// - D2h/D3h echo the next data byte, marked keyboard or auxiliary.
// - D4h sends the next data byte to the auxiliary device.
// - E0h returns the state of the test inputs.
// - Even FXh commands pulse only the reset line low for 6 us while the hardware-reset bit is clear.
// - Two-bit clock-select field gives input clock: 6, 8, 12 or 16 MHz.
// - Fast-port enable lets the fast port drive gate and reset; else no effect.
// - Hardware-gate bit hands the gate output to the hardware path.
// - Hardware-reset bit hands the keyboard reset output to the hardware path.
// - Hardware path: data after D1 sets gate from bit 1.
// - Hardware path: data after D1 sets keyboard reset from bit 0.
// - Hardware path: FE waits 14 us then drives reset low 6 us.
// - Gate and reset come from software or hardware path, never both.
// - With fast port enabled, outputs merge controller control with fast port values.
// - Fast port bit 1 drives the gate high when 1; when 0 the gate follows the controller path.
// - Fast port reset bit gives a delayed low reset pulse; cleared before repeat.
// - Loading a result sets output-buffer-full; a data port read clears it.
`ifndef KGR_REGS_SVH
`define KGR_REGS_SVH

`define KGR_IO_DATA 16'h0060
`define KGR_IO_CMD 16'h0064
`define KGR_IO_FAST 16'h0092
`define KGR_CFG_FPC 8'hf0
`define KGR_FPC_RESET 8'h00
`define KGR_FPC_MASK 8'hc7
`define KGR_FAST_RSVD 8'h24

`define KGR_CMD_SELFTEST 8'haa
`define KGR_CMD_IFTEST 8'hab
`define KGR_CMD_KBD_OFF 8'had
`define KGR_CMD_KBD_ON 8'hae
`define KGR_CMD_RD_INP 8'hc0
`define KGR_CMD_NIB_LO 8'hc1
`define KGR_CMD_NIB_HI 8'hc2
`define KGR_CMD_RD_OUTP 8'hd0
`define KGR_CMD_WR_GATE 8'hd1
`define KGR_CMD_ECHO_KBD 8'hd2
`define KGR_CMD_ECHO_AUX 8'hd3
`define KGR_CMD_TO_AUX 8'hd4
`define KGR_CMD_RD_TEST 8'he0
`define KGR_CMD_FE 8'hfe
`define KGR_CMD_FX_HI 4'hf

`define KGR_SELFTEST_OK 8'h55
`define KGR_IF_OK 8'h00
`define KGR_IF_CLK_LOW 8'h01
`define KGR_IF_DATA_LOW 8'h03

`define KGR_MHZ_SEL0 8'h06
`define KGR_MHZ_SEL1 8'h08
`define KGR_MHZ_SEL2 8'h0c
`define KGR_MHZ_SEL3 8'h10

`define KGR_CLK_PERIOD_NS 20
`define KGR_T_DELAY_NS 14000
`define KGR_T_PULSE_NS 6000
`define KGR_T_SW_DELAY_NS 20

`endif

// *** src/kgr_pkg.sv ***
// Types shared by the gate/reset block and its bench
package kgr_pkg;

	typedef struct packed {
		logic [1:0] clk_rate_sel;
		logic [2:0] rsvd;
		logic fast_port_enable;
		logic hw_gate_enable;
		logic hw_reset_enable;
	} kgr_fpc_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} kgr_byte_t;

	typedef enum logic [1:0] {
		KGR_IDLE,
		KGR_WAIT_DATA
	} kgr_state_t;

	typedef enum logic [1:0] {
		KGR_NIB_OFF,
		KGR_NIB_LO,
		KGR_NIB_HI
	} kgr_nib_t;

endpackage : kgr_pkg

// *** src/kgr_pulse.sv ***
// Delayed low-pulse timer: waits a delay, then holds its output for a width
`timescale 1ns/100ps
`default_nettype none
module kgr_pulse #(
	parameter int DELAY_CYC = 1,
	parameter int WIDTH_CYC = 1
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Control
	input wire logic trig_i,
	output logic busy_o,
	output logic low_o
);
	localparam logic [9:0] DLY_M1 = 10'(DELAY_CYC - 1);
	localparam logic [9:0] WID_M1 = 10'(WIDTH_CYC - 1);

	logic [9:0] cnt;
	logic waiting;

	// Trigger while busy is ignored
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt <= 10'h000;
			waiting <= 1'b0;
			busy_o <= 1'b0;
			low_o <= 1'b0;
		end else if (!busy_o) begin
			if (trig_i) begin
				busy_o <= 1'b1;
				waiting <= 1'b1;
				cnt <= DLY_M1;
			end
		end else if (cnt != 10'h000) begin
			cnt <= cnt - 10'h001;
		end else if (waiting) begin
			waiting <= 1'b0;
			low_o <= 1'b1;
			cnt <= WID_M1;
		end else begin
			low_o <= 1'b0;
			busy_o <= 1'b0;
		end
	end
endmodule : kgr_pulse
`default_nettype wire

// *** src/kgr_top.sv ***
// Command decoder with gate and keyboard reset fast path
`timescale 1ns/100ps
`default_nettype none
`include "kgr_regs.svh"
module kgr_top (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Host I/O port access
	input wire logic [15:0] io_addr_i,
	input wire logic io_wr_i,
	input wire logic io_rd_i,
	input wire logic [7:0] io_wdata_i,
	output logic [7:0] io_rdata_o,
	output logic io_rvalid_o,
	// Configuration register access
	input wire logic [7:0] cfg_index_i,
	input wire logic cfg_wr_i,
	input wire logic cfg_rd_i,
	input wire logic [7:0] cfg_wdata_i,
	output logic [7:0] cfg_rdata_o,
	// Pins from outside
	input wire logic kbd_clk_i,
	input wire logic kbd_data_i,
	input wire logic [7:0] input_port_i,
	input wire logic [1:0] test_in_i,
	// Bytes toward keyboard and auxiliary device
	output kgr_pkg::kgr_byte_t kbd_tx_o,
	output kgr_pkg::kgr_byte_t aux_tx_o,
	// Gate and reset pins
	output logic addr_line20_gate_o,
	output logic keyboard_reset_out_n_o,
	// Clock rate in MHz told by the select field
	output logic [7:0] clk_rate_mhz_o,
	// Status flags
	output logic obf_o,
	output logic aux_obf_o
);
	import kgr_pkg::*;

	localparam int DLY_CYC = (`KGR_T_DELAY_NS + `KGR_CLK_PERIOD_NS - 1) / `KGR_CLK_PERIOD_NS;
	localparam int PUL_CYC = (`KGR_T_PULSE_NS + `KGR_CLK_PERIOD_NS - 1) / `KGR_CLK_PERIOD_NS;
	localparam int SW_DLY_CYC = (`KGR_T_SW_DELAY_NS + `KGR_CLK_PERIOD_NS - 1) /
		`KGR_CLK_PERIOD_NS;

	// Pin synchronisers
	logic [11:0] pin_meta;
	logic [11:0] pin_sync;
	wire [11:0] pin_raw = {test_in_i, input_port_i, kbd_data_i, kbd_clk_i};

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_meta <= 12'h000;
			pin_sync <= 12'h000;
		end else begin
			pin_meta <= pin_raw;
			pin_sync <= pin_meta;
		end
	end

	wire kbd_clk_s = pin_sync[0];
	wire kbd_data_s = pin_sync[1];
	wire [7:0] inport_s = pin_sync[9:2];
	wire [1:0] test_s = pin_sync[11:10];

	// Address decode
	wire wr_data = io_wr_i && (io_addr_i == `KGR_IO_DATA);
	wire wr_cmd = io_wr_i && (io_addr_i == `KGR_IO_CMD);
	wire wr_fast = io_wr_i && (io_addr_i == `KGR_IO_FAST);
	wire rd_data = io_rd_i && (io_addr_i == `KGR_IO_DATA);
	wire rd_stat = io_rd_i && (io_addr_i == `KGR_IO_CMD);
	wire rd_fast = io_rd_i && (io_addr_i == `KGR_IO_FAST);
	wire cfg_hit_wr = cfg_wr_i && (cfg_index_i == `KGR_CFG_FPC);
	wire cfg_hit_rd = cfg_rd_i && (cfg_index_i == `KGR_CFG_FPC);

	// Configuration and state
	kgr_fpc_t fpc;
	kgr_state_t state;
	kgr_state_t next_state;
	kgr_nib_t nib_mode;
	logic [7:0] pend_cmd;
	logic [7:0] out_buf;
	logic obf;
	logic aux_obf;
	logic cmd_flag;
	logic kbd_enable;
	logic [3:0] stat_nib;
	logic sw_gate;
	logic hw_gate;
	logic hw_rst_n;
	logic fast_gate_value;
	logic fast_reset_request;
	logic sw_busy;
	logic sw_low;
	logic fe_busy;
	logic fe_low;
	logic fast_busy;
	logic fast_low;

	// Command classification
	wire [7:0] cmd = io_wdata_i;
	wire fx_even = (cmd[7:4] == `KGR_CMD_FX_HI) && !cmd[0];
	wire needs_data = (cmd == `KGR_CMD_WR_GATE) || (cmd == `KGR_CMD_ECHO_KBD) ||
		(cmd == `KGR_CMD_ECHO_AUX) || (cmd == `KGR_CMD_TO_AUX);
	wire data_taken = wr_data && (state == KGR_WAIT_DATA);
	wire gate_data = data_taken && (pend_cmd == `KGR_CMD_WR_GATE);

	// Interface test: idle lines read high; stuck-high cannot be seen without driving
	wire [7:0] if_result = !kbd_clk_s ? `KGR_IF_CLK_LOW :
		(!kbd_data_s ? `KGR_IF_DATA_LOW : `KGR_IF_OK);

	wire [7:0] out_port = {6'h00, addr_line20_gate_o, keyboard_reset_out_n_o};

	// Result byte selection for commands
	logic cmd_load;
	logic [7:0] cmd_byte;

	always_comb begin
		cmd_load = 1'b1;
		cmd_byte = 8'h00;
		case (cmd)
			`KGR_CMD_SELFTEST: cmd_byte = `KGR_SELFTEST_OK;
			`KGR_CMD_IFTEST: cmd_byte = if_result;
			`KGR_CMD_RD_INP: cmd_byte = inport_s;
			`KGR_CMD_RD_OUTP: cmd_byte = out_port;
			`KGR_CMD_RD_TEST: cmd_byte = {6'h00, test_s};
			default: cmd_load = 1'b0;
		endcase
	end

	wire load_cmd = wr_cmd && cmd_load;
	wire load_echo = data_taken && ((pend_cmd == `KGR_CMD_ECHO_KBD) ||
		(pend_cmd == `KGR_CMD_ECHO_AUX));
	wire echo_aux = pend_cmd == `KGR_CMD_ECHO_AUX;
	wire ob_load = load_cmd || load_echo;
	wire [7:0] ob_byte = load_echo ? io_wdata_i : cmd_byte;

	// Command sequencing
	always_comb begin
		next_state = state;
		case (state)
			KGR_IDLE: if (wr_cmd && needs_data) begin
				next_state = KGR_WAIT_DATA;
			end
			KGR_WAIT_DATA: if (wr_data) begin
				next_state = KGR_IDLE;
			end else if (wr_cmd && !needs_data) begin
				next_state = KGR_IDLE;
			end
			default: next_state = KGR_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= KGR_IDLE;
			pend_cmd <= 8'h00;
		end else begin
			state <= next_state;
			if (wr_cmd) begin
				pend_cmd <= cmd;
			end
		end
	end

	// Output buffer; a load in the read cycle keeps the flag set
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			out_buf <= 8'h00;
			obf <= 1'b0;
			aux_obf <= 1'b0;
		end else if (ob_load) begin
			out_buf <= ob_byte;
			obf <= 1'b1;
			aux_obf <= load_echo && echo_aux;
		end else if (rd_data) begin
			obf <= 1'b0;
			aux_obf <= 1'b0;
		end
	end

	// Status nibble copy mode and keyboard enable
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			nib_mode <= KGR_NIB_OFF;
			kbd_enable <= 1'b1;
			cmd_flag <= 1'b0;
		end else begin
			if (wr_cmd) begin
				cmd_flag <= 1'b1;
			end else if (wr_data) begin
				cmd_flag <= 1'b0;
			end
			if (wr_cmd && (cmd == `KGR_CMD_NIB_LO)) begin
				nib_mode <= KGR_NIB_LO;
			end else if (wr_cmd && (cmd == `KGR_CMD_NIB_HI)) begin
				nib_mode <= KGR_NIB_HI;
			end else if (wr_cmd) begin
				nib_mode <= KGR_NIB_OFF;
			end
			if (wr_cmd && (cmd == `KGR_CMD_KBD_OFF)) begin
				kbd_enable <= 1'b0;
			end else if (wr_cmd && (cmd == `KGR_CMD_KBD_ON)) begin
				kbd_enable <= 1'b1;
			end
		end
	end

	always_comb begin
		case (nib_mode)
			KGR_NIB_LO: stat_nib = inport_s[3:0];
			KGR_NIB_HI: stat_nib = inport_s[7:4];
			default: stat_nib = {1'b0, 1'b0, 1'b0, 1'b0};
		endcase
	end

	wire [7:0] status = nib_mode == KGR_NIB_OFF ?
		{2'b00, aux_obf, kbd_enable, cmd_flag, 1'b0, 1'b0, obf} :
		{stat_nib, cmd_flag, 1'b0, 1'b0, obf};

	// Bytes sent on to keyboard or auxiliary device
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			kbd_tx_o <= '0;
			aux_tx_o <= '0;
		end else begin
			kbd_tx_o.valid <= wr_data && (state == KGR_IDLE);
			aux_tx_o.valid <= data_taken && (pend_cmd == `KGR_CMD_TO_AUX);
			if (wr_data) begin
				kbd_tx_o.data <= io_wdata_i;
				aux_tx_o.data <= io_wdata_i;
			end
		end
	end

	// Fast-path control register
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			fpc <= kgr_fpc_t'(`KGR_FPC_RESET);
		end else if (cfg_hit_wr) begin
			fpc <= kgr_fpc_t'(cfg_wdata_i & `KGR_FPC_MASK);
		end
	end

	// Gate and reset sources of software and hardware paths
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sw_gate <= 1'b0;
			hw_gate <= 1'b0;
			hw_rst_n <= 1'b1;
		end else if (gate_data) begin
			if (fpc.hw_gate_enable) begin
				hw_gate <= io_wdata_i[1];
			end else begin
				sw_gate <= io_wdata_i[1];
			end
			if (fpc.hw_reset_enable) begin
				hw_rst_n <= io_wdata_i[0];
			end
		end
	end

	// Fast gate/reset port; reset request fires on its 0 to 1 write
	wire fast_rst_rise = wr_fast && io_wdata_i[0] && !fast_reset_request;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			fast_gate_value <= 1'b0;
			fast_reset_request <= 1'b0;
		end else if (wr_fast) begin
			fast_gate_value <= io_wdata_i[1];
			fast_reset_request <= io_wdata_i[0];
		end
	end

	wire [7:0] fast_port = `KGR_FAST_RSVD | {6'h00, fast_gate_value, fast_reset_request};

	// Reset pulse timers
	wire sw_trig = wr_cmd && fx_even && !fpc.hw_reset_enable;
	wire fe_trig = wr_cmd && (cmd == `KGR_CMD_FE) && fpc.hw_reset_enable;
	wire fast_trig = fast_rst_rise && fpc.fast_port_enable;

	kgr_pulse #(
		.DELAY_CYC(SW_DLY_CYC),
		.WIDTH_CYC(PUL_CYC)
	) u_sw_pulse (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.trig_i(sw_trig),
		.busy_o(sw_busy),
		.low_o(sw_low)
	);

	kgr_pulse #(
		.DELAY_CYC(DLY_CYC),
		.WIDTH_CYC(PUL_CYC)
	) u_fe_pulse (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.trig_i(fe_trig),
		.busy_o(fe_busy),
		.low_o(fe_low)
	);

	kgr_pulse #(
		.DELAY_CYC(DLY_CYC),
		.WIDTH_CYC(PUL_CYC)
	) u_fast_pulse (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.trig_i(fast_trig),
		.busy_o(fast_busy),
		.low_o(fast_low)
	);

	// Output merge: one controller path, then OR with the fast port
	wire ctl_gate = fpc.hw_gate_enable ? hw_gate : sw_gate;
	wire ctl_rst_low = fpc.hw_reset_enable ? (fe_low || !hw_rst_n) : sw_low;
	wire next_gate = ctl_gate || (fpc.fast_port_enable && fast_gate_value);
	wire next_rst_low = ctl_rst_low || (fpc.fast_port_enable && fast_low);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			addr_line20_gate_o <= 1'b0;
			keyboard_reset_out_n_o <= 1'b1;
		end else begin
			addr_line20_gate_o <= next_gate;
			keyboard_reset_out_n_o <= !next_rst_low;
		end
	end

	// Clock rate told by the select field
	logic [7:0] next_mhz;

	always_comb begin
		case (fpc.clk_rate_sel)
			2'h0: next_mhz = `KGR_MHZ_SEL0;
			2'h1: next_mhz = `KGR_MHZ_SEL1;
			2'h2: next_mhz = `KGR_MHZ_SEL2;
			default: next_mhz = `KGR_MHZ_SEL3;
		endcase
	end

	// Read answers, one cycle after the strobe
	wire io_hit = rd_data || rd_stat || rd_fast;
	wire [7:0] next_io_rdata = rd_data ? out_buf : (rd_stat ? status :
		(rd_fast ? fast_port : 8'h00));

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			io_rdata_o <= 8'h00;
			io_rvalid_o <= 1'b0;
			cfg_rdata_o <= 8'h00;
			clk_rate_mhz_o <= `KGR_MHZ_SEL0;
			obf_o <= 1'b0;
			aux_obf_o <= 1'b0;
		end else begin
			io_rvalid_o <= io_hit;
			if (io_hit) begin
				io_rdata_o <= next_io_rdata;
			end
			if (cfg_hit_rd) begin
				cfg_rdata_o <= fpc;
			end else if (cfg_rd_i) begin
				cfg_rdata_o <= 8'h00;
			end
			clk_rate_mhz_o <= next_mhz;
			obf_o <= obf;
			aux_obf_o <= aux_obf;
		end
	end

endmodule : kgr_top
`default_nettype wire

// *** verif/kgr_top_asserts.sv ***
// Assertion checker for the gate/reset command block
`timescale 1ns/100ps
`default_nettype none
module kgr_top_asserts (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Host and config access
	input wire logic [15:0] io_addr_i,
	input wire logic io_wr_i,
	input wire logic io_rd_i,
	input wire logic [7:0] io_wdata_i,
	input wire logic [7:0] cfg_index_i,
	input wire logic cfg_wr_i,
	input wire logic [7:0] cfg_wdata_i,
	// Observed outputs
	input wire logic io_rvalid_o,
	input wire logic addr_line20_gate_o,
	input wire logic keyboard_reset_out_n_o,
	input wire logic [7:0] clk_rate_mhz_o,
	input wire logic obf_o
);
	logic [7:0] fpc;
	logic fgate, freq, d1_pend, gsh;
	logic [10:0] low_cnt, dly_cnt;
	wire cmd_wr = io_wr_i && io_addr_i == 16'h0064;
	wire dat_wr = io_wr_i && io_addr_i == 16'h0060;
	wire fst_wr = io_wr_i && io_addr_i == 16'h0092;
	wire hit = io_addr_i == 16'h0060 || io_addr_i == 16'h0064 || io_addr_i == 16'h0092;
	wire fx_even = cmd_wr && io_wdata_i[7:4] == 4'hf && !io_wdata_i[0];
	wire idle = keyboard_reset_out_n_o && dly_cnt == 11'h000;
	wire dly_go = idle && ((cmd_wr && io_wdata_i == 8'hfe && fpc[0])
		|| (fst_wr && fpc[2] && io_wdata_i[0] && !freq));
	function automatic logic [7:0] rate(input logic [1:0] s);
		return (s == 2'h0) ? 8'h06 : (s == 2'h1) ? 8'h08 : (s == 2'h2) ? 8'h0c : 8'h10;
	endfunction : rate
	// Shadows of config, fast port and pulse timing
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			fpc <= 8'h00;
			{fgate, freq, d1_pend, gsh} <= 4'h0;
			low_cnt <= 11'h000;
			dly_cnt <= 11'h000;
		end else begin
			if (cfg_wr_i && cfg_index_i == 8'hf0)
				fpc <= cfg_wdata_i;
			if (fst_wr)
				{fgate, freq} <= io_wdata_i[1:0];
			if (cmd_wr || dat_wr)
				d1_pend <= cmd_wr && io_wdata_i == 8'hd1;
			if (dat_wr && d1_pend)
				gsh <= io_wdata_i[1];
			low_cnt <= keyboard_reset_out_n_o ? 11'h000 : low_cnt + 11'h001;
			if (dly_go)
				dly_cnt <= 11'h001;
			else if (dly_cnt != 11'h000)
				dly_cnt <= (dly_cnt == 11'd1000) ? 11'h000 : dly_cnt + 11'h001;
		end
	end
	property p_rvalid;
		@(posedge clk_i) disable iff (rst_i) io_rd_i && hit |=> io_rvalid_o;
	endproperty
	a_rvalid: assert property (p_rvalid) else $error("read hit without rvalid");
	property p_unmapped;
		@(posedge clk_i) disable iff (rst_i) io_rd_i && !hit |=> !io_rvalid_o;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("rvalid on unmapped read");
	property p_selftest;
		@(posedge clk_i) disable iff (rst_i) cmd_wr && io_wdata_i == 8'haa |-> ##2 obf_o;
	endproperty
	a_selftest: assert property (p_selftest) else $error("self test left buffer empty");
	property p_obf_clear;
		@(posedge clk_i) disable iff (rst_i)
			io_rd_i && io_addr_i == 16'h0060 && obf_o |-> ##2 !obf_o;
	endproperty
	a_obf_clear: assert property (p_obf_clear) else $error("buffer full after read");
	property p_rate;
		@(posedge clk_i) disable iff (rst_i) cfg_wr_i && cfg_index_i == 8'hf0
			|-> ##2 clk_rate_mhz_o == rate($past(cfg_wdata_i[7:6], 2));
	endproperty
	a_rate: assert property (p_rate) else $error("clock rate mismatch");
	property p_gate_d1;
		@(posedge clk_i) disable iff (rst_i) dat_wr && d1_pend
			|-> ##2 addr_line20_gate_o == ($past(io_wdata_i[1], 2) | (fpc[2] & fgate));
	endproperty
	a_gate_d1: assert property (p_gate_d1) else $error("gate not from data bit 1");
	property p_rst_d1;
		@(posedge clk_i) disable iff (rst_i) dat_wr && d1_pend && fpc[0] && idle && !freq
			|-> ##2 keyboard_reset_out_n_o == $past(io_wdata_i[0], 2);
	endproperty
	a_rst_d1: assert property (p_rst_d1) else $error("reset not from data bit 0");
	property p_fast_gate;
		@(posedge clk_i) disable iff (rst_i)
			fst_wr |-> ##2 addr_line20_gate_o == (gsh | (fpc[2] & $past(io_wdata_i[1], 2)));
	endproperty
	a_fast_gate: assert property (p_fast_gate) else $error("fast gate merge wrong");
	property p_fx_start;
		@(posedge clk_i) disable iff (rst_i)
			fx_even && !fpc[0] && idle |-> ##[1:4] !keyboard_reset_out_n_o;
	endproperty
	a_fx_start: assert property (p_fx_start) else $error("even command gave no pulse");
	property p_width;
		@(posedge clk_i) disable iff (rst_i)
			$rose(keyboard_reset_out_n_o) && !fpc[0] |-> low_cnt >= 11'd300;
	endproperty
	a_width: assert property (p_width) else $error("reset pulse too short");
	property p_hold;
		@(posedge clk_i) disable iff (rst_i)
			dly_cnt != 11'h000 && dly_cnt < 11'd700 |-> keyboard_reset_out_n_o;
	endproperty
	a_hold: assert property (p_hold) else $error("reset before delay ran out");
	property p_late_low;
		@(posedge clk_i) disable iff (rst_i) dly_cnt == 11'd800 |-> !keyboard_reset_out_n_o;
	endproperty
	a_late_low: assert property (p_late_low) else $error("delayed pulse missing");
endmodule : kgr_top_asserts
bind kgr_top kgr_top_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .io_addr_i(io_addr_i),
	.io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .cfg_index_i(cfg_index_i),
	.cfg_wr_i(cfg_wr_i), .cfg_wdata_i(cfg_wdata_i), .io_rvalid_o(io_rvalid_o),
	.addr_line20_gate_o(addr_line20_gate_o), .keyboard_reset_out_n_o(keyboard_reset_out_n_o),
	.clk_rate_mhz_o(clk_rate_mhz_o), .obf_o(obf_o));
`default_nettype wire

// *** verif/kgr_host.sv ***
// Host processor model issuing I/O cycles
`timescale 1ns/100ps
`default_nettype none
module kgr_host (
	// Clock and answers
	input wire logic clk_i,
	input wire logic [7:0] rdata_i,
	input wire logic rvalid_i,
	input wire logic obf_i,
	// I/O cycle
	output logic [15:0] addr_o,
	output logic wr_o,
	output logic rd_o,
	output logic [7:0] wdata_o
);
	initial begin
		addr_o = 16'hffff;
		{wr_o, rd_o} = 2'b00;
		wdata_o = 8'h00;
	end
	// Released bus shows inverted values
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk_i);
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(negedge clk_i);
		wr_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~d;
	endtask : wr
	task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
		for (int i = 0; i < 8 && a == 16'h0060 && obf_i !== 1'b1; i++) @(negedge clk_i);
		@(negedge clk_i);
		addr_o = a;
		rd_o = 1'b1;
		@(negedge clk_i);
		rd_o = 1'b0;
		addr_o = ~a;
		ok = rvalid_i;
		d = rdata_i;
	endtask : rd
endmodule : kgr_host
`default_nettype wire

// *** verif/kgr_top_bench.sv ***
// Self-checking bench for the gate/reset command block
`timescale 1ns/100ps
`default_nettype none
module kgr_top_bench;
	import kgr_pkg::*;
	logic clk_i = 1'b0, rst_i = 1'b1, io_wr, io_rd, io_rvalid, cfg_wr = 1'b0, cfg_rd = 1'b0;
	logic [15:0] io_addr;
	logic [7:0] io_wdata, io_rdata, cfg_index = 8'hf0, cfg_wdata = 8'h00, cfg_rdata, rate;
	logic kclk = 1'b1, kdat = 1'b1, gate, rst_n, obf, aux_obf, ok;
	logic [7:0] inp = 8'ha5, v, aux_seen, kbd_seen;
	logic [1:0] tin = 2'h2;
	kgr_byte_t kbd_tx, aux_tx;
	int checks = 0, n_mismatch = 0, cyc = 0, dly, wid;
	always #10 clk_i = ~clk_i;
	kgr_top DUT (.clk_i(clk_i), .rst_i(rst_i), .io_addr_i(io_addr), .io_wr_i(io_wr),
		.io_rd_i(io_rd), .io_wdata_i(io_wdata), .io_rdata_o(io_rdata), .io_rvalid_o(io_rvalid),
		.cfg_index_i(cfg_index), .cfg_wr_i(cfg_wr), .cfg_rd_i(cfg_rd), .cfg_wdata_i(cfg_wdata),
		.cfg_rdata_o(cfg_rdata), .kbd_clk_i(kclk), .kbd_data_i(kdat), .input_port_i(inp),
		.test_in_i(tin), .kbd_tx_o(kbd_tx), .aux_tx_o(aux_tx), .addr_line20_gate_o(gate),
		.keyboard_reset_out_n_o(rst_n), .clk_rate_mhz_o(rate), .obf_o(obf), .aux_obf_o(aux_obf));
	kgr_host hst (.clk_i(clk_i), .rdata_i(io_rdata), .rvalid_i(io_rvalid), .obf_i(obf),
		.addr_o(io_addr), .wr_o(io_wr), .rd_o(io_rd), .wdata_o(io_wdata));
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (aux_tx.valid === 1'b1)
			aux_seen <= aux_tx.data;
		if (kbd_tx.valid === 1'b1)
			kbd_seen <= kbd_tx.data;
		if (cyc == 30000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		$display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic cfg(input logic [7:0] d);
		@(negedge clk_i);
		{cfg_wdata, cfg_wr} = {d, 1'b1};
		@(negedge clk_i);
		{cfg_wdata, cfg_wr} = {~d, 1'b0};
		repeat (2) @(negedge clk_i);
	endtask : cfg
	task automatic cmd(input logic [15:0] a, input logic [7:0] d);
		hst.wr(a, d);
		repeat (3) @(negedge clk_i);
	endtask : cmd
	task automatic res(input logic [7:0] c, input logic [7:0] e);
		// Pin changes need two edges through the synchroniser
		repeat (2) @(negedge clk_i);
		cmd(16'h0064, c);
		hst.rd(16'h0060, v, ok);
		chk({v[7:1], v[0] & ok}, e);
	endtask : res
	task automatic pulse(input int lim);
		for (dly = 0; rst_n === 1'b1 && dly < lim; dly++) @(negedge clk_i);
		for (wid = 0; rst_n === 1'b0 && wid < 2000; wid++) @(negedge clk_i);
	endtask : pulse
	task automatic t_results();
		res(8'hab, 8'h00);
		kclk = 1'b0;
		res(8'hab, 8'h01);
		{kclk, kdat} = 2'b10;
		res(8'hab, 8'h03);
		kdat = 1'b1;
		res(8'haa, 8'h55);
		res(8'hc0, 8'ha5);
		res(8'he0, 8'h02);
		res(8'hd0, 8'h01);
		hst.rd(16'h0070, v, ok);
		chk({7'h0, ok}, 8'h00);
		cmd(16'h0064, 8'hc1);
		hst.rd(16'h0064, v, ok);
		chk({4'h0, v[7:4]}, 8'h05);
		cmd(16'h0064, 8'hc2);
		hst.rd(16'h0064, v, ok);
		chk({4'h0, v[7:4]}, 8'h0a);
		res(8'haa, 8'h55);
	endtask : t_results
	task automatic t_pass();
		cmd(16'h0064, 8'hd2);
		cmd(16'h0060, 8'h3c);
		hst.rd(16'h0064, v, ok);
		chk({7'h0, v[5]}, 8'h00);
		hst.rd(16'h0060, v, ok);
		chk(v, 8'h3c);
		cmd(16'h0064, 8'hd3);
		cmd(16'h0060, 8'hc3);
		hst.rd(16'h0064, v, ok);
		chk({7'h0, v[5]}, 8'h01);
		hst.rd(16'h0060, v, ok);
		chk(v, 8'hc3);
		cmd(16'h0064, 8'hd4);
		cmd(16'h0060, 8'h5a);
		chk(aux_seen, 8'h5a);
		cmd(16'h0060, 8'h96);
		chk(kbd_seen, 8'h96);
	endtask : t_pass
	task automatic t_rate();
		for (int s = 0; s < 4; s++) begin
			cfg({s[1:0], 6'h00});
			chk(rate, (s == 0) ? 8'h06 : (s == 1) ? 8'h08 : (s == 2) ? 8'h0c : 8'h10);
		end
		cfg(8'h00);
	endtask : t_rate
	task automatic t_reset_pulse();
		hst.wr(16'h0064, 8'hf0);
		pulse(2000);
		chk({7'h0, wid == 300}, 8'h01);
		cmd(16'h0064, 8'hf1);
		pulse(1000);
		chk({7'h0, dly == 1000}, 8'h01);
		cfg(8'h01);
		hst.wr(16'h0064, 8'hfe);
		pulse(2000);
		chk({7'h0, dly >= 690 && dly <= 720 && wid >= 300}, 8'h01);
		cmd(16'h0064, 8'hd1);
		cmd(16'h0060, 8'h00);
		chk({7'h0, rst_n}, 8'h00);
		cmd(16'h0064, 8'hd1);
		cmd(16'h0060, 8'h01);
		chk({7'h0, rst_n}, 8'h01);
		cfg(8'h00);
	endtask : t_reset_pulse
	task automatic t_fast();
		cfg(8'h04);
		cmd(16'h0092, 8'h02);
		chk({7'h0, gate}, 8'h01);
		hst.rd(16'h0092, v, ok);
		chk(v, 8'h26);
		hst.wr(16'h0092, 8'h03);
		pulse(2000);
		chk({7'h0, dly >= 690 && dly <= 720 && wid >= 300}, 8'h01);
		cmd(16'h0092, 8'h00);
		chk({7'h0, gate}, 8'h00);
		cmd(16'h0064, 8'hd1);
		cmd(16'h0060, 8'h02);
		chk({7'h0, gate}, 8'h01);
		cmd(16'h0064, 8'hd1);
		cmd(16'h0060, 8'h00);
		cfg(8'h00);
		cmd(16'h0092, 8'h02);
		chk({7'h0, gate}, 8'h00);
		cmd(16'h0092, 8'h00);
	endtask : t_fast
	task automatic t_gate();
		cmd(16'h0064, 8'hd1);
		cmd(16'h0060, 8'h02);
		chk({7'h0, gate}, 8'h01);
		res(8'hd0, 8'h03);
		cfg(8'h02);
		cmd(16'h0064, 8'hd1);
		cmd(16'h0060, 8'h00);
		chk({7'h0, gate}, 8'h00);
		cfg(8'h00);
		chk({7'h0, gate}, 8'h01);
	endtask : t_gate
	initial begin
		repeat (8) @(negedge clk_i);
		rst_i = 1'b0;
		chk({rate[6:1], gate, rst_n}, 8'h0d);
		@(negedge clk_i);
		{cfg_rd, cfg_index} = {1'b1, 8'hf0};
		@(negedge clk_i);
		cfg_rd = 1'b0;
		chk(cfg_rdata, 8'h00);
		t_results();
		t_pass();
		t_rate();
		t_reset_pulse();
		t_fast();
		t_gate();
		tally_and_finish();
	end
endmodule : kgr_top_bench
`default_nettype wire
